// >>> design/gpe_defines.vh
`ifndef GPE_DEFINES_VH
`define GPE_DEFINES_VH

// register indices; byte address is four times the index
`define GPE_IDX_H_OUTPUT 8'h20
`define GPE_IDX_H_PIN_LEVELS 8'h21
`define GPE_IDX_H_DIRECTION 8'h22
`define GPE_IDX_H_DRIVE 8'h23
`define GPE_IDX_H_PULL_EN 8'h24
`define GPE_IDX_H_POLARITY 8'h25
`define GPE_IDX_H_IRQ_EN 8'h26
`define GPE_IDX_H_FLAGS 8'h27
`define GPE_IDX_J_DATA 8'h28
`define GPE_IDX_J_DIRECTION 8'h2a
`define GPE_IDX_EVT_STATUS 8'h30
`define GPE_IDX_EVT_MASK 8'h31

`define GPE_ADDR_W 12
`define GPE_IDX_MSB 9
`define GPE_IDX_LSB 2
`define GPE_HI_MSB 11
`define GPE_HI_LSB 10

`define GPE_REG_RESET 8'h00
`define GPE_J_IMPL_MASK 8'hc3
`define GPE_J_CAN_TX_BIT 7
`define GPE_J_CAN_RX_BIT 6
`define GPE_J_SCL_BIT 7
`define GPE_J_SDA_BIT 6

`define GPE_RESP_OKAY 2'b00
`define GPE_RESP_SLVERR 2'b10

`endif

// >>> design/gpe_port.v
// How it works
// RQ1: input register reads pin levels, ignores writes
// RQ2: direction bit zero input, one output
// RQ3: drive bit selects reduced drive, outputs only
// RQ4: pull enable only on inputs, off after reset
// RQ5: polarity zero: falling edge, pull-up
// RQ6: polarity one: rising edge, pull-down
// RQ7: enable bit masks or allows each pin
// RQ8: active edge sets the pin's flag
// RQ9: write one clears flag, zero keeps
// RQ10: interrupt while flag and enable both set
// RQ11: port J: CAN, then I2C, then GPIO
// RQ12: I2C owns port J: open-drain outputs
// RQ13: port J in reset: inputs with pull-up
// RQ14: port J read: output value or pin level
// RQ15: port J implements bits 7,6,1,0 only
// RQ16: SPI controllers override port H GPIO
// RQ17: port H in reset: high-impedance inputs
// RQ18: pins synchronised before edge detection
`timescale 1ns/1ps
`include "gpe_defines.vh"

module gpe_port (
	input wire aclk,
	input wire aresetn,
	input wire [11:0] s_axi_awaddr,
	input wire [2:0] s_axi_awprot,
	input wire s_axi_awvalid,
	output wire s_axi_awready,
	input wire [31:0] s_axi_wdata,
	input wire [3:0] s_axi_wstrb,
	input wire s_axi_wvalid,
	output wire s_axi_wready,
	output wire [1:0] s_axi_bresp,
	output wire s_axi_bvalid,
	input wire s_axi_bready,
	input wire [11:0] s_axi_araddr,
	input wire [2:0] s_axi_arprot,
	input wire s_axi_arvalid,
	output wire s_axi_arready,
	output wire [31:0] s_axi_rdata,
	output wire [1:0] s_axi_rresp,
	output wire s_axi_rvalid,
	input wire s_axi_rready,
	input wire [7:0] port_h_pin_in,
	output reg [7:0] port_h_pin_out,
	output reg [7:0] port_h_pin_oe,
	output reg [7:0] port_h_reduced_drive,
	output reg [7:0] port_h_pull_en,
	output reg [7:0] port_h_pull_up,
	input wire first_serial_periph_if_en,
	input wire [3:0] first_serial_periph_if_out,
	input wire [3:0] first_serial_periph_if_oe,
	input wire second_serial_periph_if_en,
	input wire [3:0] second_serial_periph_if_out,
	input wire [3:0] second_serial_periph_if_oe,
	output wire [7:0] port_h_periph_in,
	input wire [7:0] port_j_pin_in,
	output reg [7:0] port_j_pin_out,
	output reg [7:0] port_j_pin_oe,
	output reg [7:0] port_j_pull_en,
	output reg [7:0] port_j_pull_up,
	input wire shared_can_controller_en,
	input wire can_transmit_pin,
	output wire can_receive_pin,
	input wire i2c_en,
	input wire i2c_scl_drive_low,
	input wire i2c_sda_drive_low,
	output wire i2c_scl_in,
	output wire i2c_sda_in,
	output wire irq
);

// ----------------------------------------
// pin synchronisers and edge detection
// ----------------------------------------
reg [7:0] h_meta_q;
reg [7:0] h_sync_q;
reg [7:0] h_prev_q;
reg [7:0] j_meta_q;
reg [7:0] j_sync_q;
wire [7:0] h_edge;

// levels reach the pin-level register two cycles, and flags three cycles, after a pin moves
// first stage feeds only the second stage
always @(posedge aclk) begin
	if (!aresetn) begin
		h_meta_q <= `GPE_REG_RESET;
		h_sync_q <= `GPE_REG_RESET;
		h_prev_q <= `GPE_REG_RESET;
		j_meta_q <= `GPE_REG_RESET;
		j_sync_q <= `GPE_REG_RESET;
	end else begin
		h_meta_q <= port_h_pin_in; // RQ18
		h_sync_q <= h_meta_q; // RQ18
		h_prev_q <= h_sync_q;
		j_meta_q <= port_j_pin_in;
		j_sync_q <= j_meta_q;
	end
end

assign port_h_periph_in = h_sync_q;
assign can_receive_pin = j_sync_q[`GPE_J_CAN_RX_BIT];
assign i2c_scl_in = j_sync_q[`GPE_J_SCL_BIT];
assign i2c_sda_in = j_sync_q[`GPE_J_SDA_BIT];

// ----------------------------------------
// registers
// ----------------------------------------
reg [7:0] h_out_q;
reg [7:0] h_dir_q;
reg [7:0] h_drv_q;
reg [7:0] h_pull_q;
reg [7:0] h_pol_q;
reg [7:0] h_ie_q;
reg [7:0] h_flag_q;
reg [7:0] h_flag_d;
reg [7:0] j_data_q;
reg [7:0] j_dir_q;
reg [7:0] evt_stat_q;
reg [7:0] evt_stat_d;
reg [7:0] evt_mask_q;

// ----------------------------------------
// axi4-lite write channel
// ----------------------------------------
reg aw_have_q;
reg [11:0] aw_addr_q;
reg w_have_q;
reg [7:0] w_data_q;
reg w_strb0_q;
reg bvalid_q;
reg [1:0] bresp_q;
wire wr_fire;
wire [7:0] wr_idx;
wire wr_hi_ok;
wire wr_en;
reg wr_hit;

// address and data are taken in either order, held until both arrive
assign s_axi_awready = !aw_have_q;
assign s_axi_wready = !w_have_q;
assign s_axi_bvalid = bvalid_q;
assign s_axi_bresp = bresp_q;
assign wr_fire = aw_have_q && w_have_q && !bvalid_q;
assign wr_idx = aw_addr_q[`GPE_IDX_MSB:`GPE_IDX_LSB];
assign wr_hi_ok = (aw_addr_q[`GPE_HI_MSB:`GPE_HI_LSB] == 2'b00);
assign wr_en = wr_fire && wr_hit && w_strb0_q;

// addresses above the map answer with an error rather than alias
always @* begin
	case (wr_idx)
		`GPE_IDX_H_OUTPUT, `GPE_IDX_H_PIN_LEVELS, `GPE_IDX_H_DIRECTION,
		`GPE_IDX_H_DRIVE, `GPE_IDX_H_PULL_EN, `GPE_IDX_H_POLARITY,
		`GPE_IDX_H_IRQ_EN, `GPE_IDX_H_FLAGS, `GPE_IDX_J_DATA,
		`GPE_IDX_J_DIRECTION, `GPE_IDX_EVT_STATUS,
		`GPE_IDX_EVT_MASK: wr_hit = wr_hi_ok;
		default: wr_hit = 1'b0;
	endcase
end

always @(posedge aclk) begin
	if (!aresetn) begin
		aw_have_q <= 1'b0;
		aw_addr_q <= 12'h000;
		w_have_q <= 1'b0;
		w_data_q <= `GPE_REG_RESET;
		w_strb0_q <= 1'b0;
		bvalid_q <= 1'b0;
		bresp_q <= `GPE_RESP_OKAY;
	end else begin
		if (s_axi_awvalid && !aw_have_q) begin
			aw_have_q <= 1'b1;
			aw_addr_q <= s_axi_awaddr;
		end
		if (s_axi_wvalid && !w_have_q) begin
			w_have_q <= 1'b1;
			w_data_q <= s_axi_wdata[7:0];
			w_strb0_q <= s_axi_wstrb[0];
		end
		if (wr_fire) begin
			aw_have_q <= 1'b0;
			w_have_q <= 1'b0;
			bvalid_q <= 1'b1;
			bresp_q <= wr_hit ? `GPE_RESP_OKAY : `GPE_RESP_SLVERR;
		end else if (bvalid_q && s_axi_bready) begin
			bvalid_q <= 1'b0;
		end
	end
end

// ----------------------------------------
// axi4-lite read channel
// ----------------------------------------
// read data is registered: the answer comes one cycle after the address
reg rvalid_q;
reg [7:0] rdata_q;
reg [1:0] rresp_q;
reg [7:0] rd_val;
reg rd_hit;
wire rd_fire;
wire [7:0] rd_idx;
wire rd_hi_ok;
wire stat_rd_clr;

assign s_axi_arready = !rvalid_q;
assign rd_fire = s_axi_arvalid && !rvalid_q;
assign rd_idx = s_axi_araddr[`GPE_IDX_MSB:`GPE_IDX_LSB];
assign rd_hi_ok = (s_axi_araddr[`GPE_HI_MSB:`GPE_HI_LSB] == 2'b00);
assign stat_rd_clr = rd_fire && rd_hit && (rd_idx == `GPE_IDX_EVT_STATUS);
assign s_axi_rvalid = rvalid_q;
assign s_axi_rdata = {24'h000000, rdata_q};
assign s_axi_rresp = rresp_q;

always @* begin
	rd_val = `GPE_REG_RESET;
	rd_hit = rd_hi_ok;
	case (rd_idx)
		`GPE_IDX_H_OUTPUT: rd_val = h_out_q;
		`GPE_IDX_H_PIN_LEVELS: rd_val = h_sync_q; // RQ1
		`GPE_IDX_H_DIRECTION: rd_val = h_dir_q;
		`GPE_IDX_H_DRIVE: rd_val = h_drv_q;
		`GPE_IDX_H_PULL_EN: rd_val = h_pull_q;
		`GPE_IDX_H_POLARITY: rd_val = h_pol_q;
		`GPE_IDX_H_IRQ_EN: rd_val = h_ie_q;
		`GPE_IDX_H_FLAGS: rd_val = h_flag_q;
		`GPE_IDX_J_DATA: rd_val = ((j_data_q & j_dir_q) |
			(j_sync_q & ~j_dir_q)) & `GPE_J_IMPL_MASK; // RQ14 RQ15
		`GPE_IDX_J_DIRECTION: rd_val = j_dir_q;
		`GPE_IDX_EVT_STATUS: rd_val = evt_stat_q;
		`GPE_IDX_EVT_MASK: rd_val = evt_mask_q;
		default: rd_hit = 1'b0;
	endcase
end

always @(posedge aclk) begin
	if (!aresetn) begin
		rvalid_q <= 1'b0;
		rdata_q <= `GPE_REG_RESET;
		rresp_q <= `GPE_RESP_OKAY;
	end else if (rd_fire) begin
		rvalid_q <= 1'b1;
		rdata_q <= rd_hit ? rd_val : `GPE_REG_RESET;
		rresp_q <= rd_hit ? `GPE_RESP_OKAY : `GPE_RESP_SLVERR;
	end else if (rvalid_q && s_axi_rready) begin
		rvalid_q <= 1'b0;
	end
end

// ----------------------------------------
// register writes, flags, event status
// ----------------------------------------
// polarity zero takes falling edges, one takes rising edges
genvar gi;
generate
	for (gi = 0; gi < 8; gi = gi + 1) begin : g_edge
		assign h_edge[gi] = h_pol_q[gi] ?
			(h_sync_q[gi] && !h_prev_q[gi]) : // RQ6
			(!h_sync_q[gi] && h_prev_q[gi]); // RQ5
	end
endgenerate

// a new edge wins over a write-one clear in the same cycle
always @* begin
	h_flag_d = h_flag_q;
	if (wr_en && wr_idx == `GPE_IDX_H_FLAGS)
		h_flag_d = h_flag_q & ~w_data_q; // RQ9
	h_flag_d = h_flag_d | h_edge; // RQ8
end

// read clear loses against an edge arriving in the same cycle
always @* begin
	evt_stat_d = evt_stat_q;
	if (stat_rd_clr)
		evt_stat_d = `GPE_REG_RESET;
	evt_stat_d = evt_stat_d | h_edge;
end

always @(posedge aclk) begin
	if (!aresetn) begin
		h_out_q <= `GPE_REG_RESET;
		h_dir_q <= `GPE_REG_RESET; // RQ17
		h_drv_q <= `GPE_REG_RESET;
		h_pull_q <= `GPE_REG_RESET; // RQ4
		h_pol_q <= `GPE_REG_RESET;
		h_ie_q <= `GPE_REG_RESET;
		h_flag_q <= `GPE_REG_RESET;
		j_data_q <= `GPE_REG_RESET;
		j_dir_q <= `GPE_REG_RESET; // RQ13
		evt_stat_q <= `GPE_REG_RESET;
		evt_mask_q <= `GPE_REG_RESET;
	end else begin
		h_flag_q <= h_flag_d;
		evt_stat_q <= evt_stat_d;
		if (wr_en) begin
			case (wr_idx)
				`GPE_IDX_H_OUTPUT: h_out_q <= w_data_q;
				`GPE_IDX_H_DIRECTION: h_dir_q <= w_data_q;
				`GPE_IDX_H_DRIVE: h_drv_q <= w_data_q;
				`GPE_IDX_H_PULL_EN: h_pull_q <= w_data_q;
				`GPE_IDX_H_POLARITY: h_pol_q <= w_data_q;
				`GPE_IDX_H_IRQ_EN: h_ie_q <= w_data_q;
				`GPE_IDX_J_DATA:
					j_data_q <= w_data_q & `GPE_J_IMPL_MASK; // RQ15
				`GPE_IDX_J_DIRECTION:
					j_dir_q <= w_data_q & `GPE_J_IMPL_MASK;
				`GPE_IDX_EVT_MASK: evt_mask_q <= w_data_q;
				default: ; // pin levels, flags and event status: no plain store (RQ1)
			endcase
		end
	end
end

// flag path gated per pin, event status gated by its own mask
assign irq = (|(h_flag_q & h_ie_q)) | (|(evt_stat_q & evt_mask_q)); // RQ7 RQ10

// ----------------------------------------
// port h pin control
// ----------------------------------------
always @* begin
	port_h_pin_out = h_out_q;
	port_h_pin_oe = h_dir_q; // RQ2
	if (first_serial_periph_if_en) begin
		port_h_pin_out[3:0] = first_serial_periph_if_out; // RQ16
		port_h_pin_oe[3:0] = first_serial_periph_if_oe; // RQ16
	end
	if (second_serial_periph_if_en) begin
		port_h_pin_out[7:4] = second_serial_periph_if_out; // RQ16
		port_h_pin_oe[7:4] = second_serial_periph_if_oe; // RQ16
	end
	// a serial block left enabled must not drive pins during reset
	if (!aresetn) begin
		port_h_pin_out = `GPE_REG_RESET; // RQ17
		port_h_pin_oe = `GPE_REG_RESET; // RQ17
	end
	// drive and pull settings only matter in the direction they fit
	port_h_reduced_drive = h_drv_q & port_h_pin_oe; // RQ3
	port_h_pull_en = h_pull_q & ~port_h_pin_oe; // RQ4
	port_h_pull_up = ~h_pol_q; // RQ5 RQ6
end

// ----------------------------------------
// port j pin control
// ----------------------------------------
always @* begin
	port_j_pin_out = j_data_q & `GPE_J_IMPL_MASK;
	port_j_pin_oe = j_dir_q & `GPE_J_IMPL_MASK;
	if (shared_can_controller_en) begin // RQ11
		port_j_pin_out[`GPE_J_CAN_TX_BIT] = can_transmit_pin;
		port_j_pin_oe[`GPE_J_CAN_TX_BIT] = 1'b1;
		port_j_pin_out[`GPE_J_CAN_RX_BIT] = 1'b0;
		port_j_pin_oe[`GPE_J_CAN_RX_BIT] = 1'b0;
	end else if (i2c_en) begin // RQ11
		// open drain: only ever pull low, never drive high
		port_j_pin_out[`GPE_J_SCL_BIT] = 1'b0; // RQ12
		port_j_pin_oe[`GPE_J_SCL_BIT] = i2c_scl_drive_low; // RQ12
		port_j_pin_out[`GPE_J_SDA_BIT] = 1'b0; // RQ12
		port_j_pin_oe[`GPE_J_SDA_BIT] = i2c_sda_drive_low; // RQ12
	end
	// can and i2c may still be enabled while the port sits in reset
	if (!aresetn) begin
		port_j_pin_out = `GPE_REG_RESET; // RQ13
		port_j_pin_oe = `GPE_REG_RESET; // RQ13
	end
	// pull-up stays on while input or wired-or, as at reset
	port_j_pull_en = `GPE_J_IMPL_MASK & ~(port_j_pin_oe & ~{i2c_en &&
		!shared_can_controller_en, i2c_en && !shared_can_controller_en,
		6'b000000}); // RQ13
	port_j_pull_up = `GPE_J_IMPL_MASK; // RQ13
end

endmodule

// >>> verif/gpe_port_properties.sv
`timescale 1ns/1ps
module gpe_port_properties (
	input wire aclk,
	input wire aresetn,
	input wire s_axi_arvalid,
	input wire s_axi_arready,
	input wire s_axi_rvalid,
	input wire [7:0] port_h_pin_in,
	input wire [7:0] port_h_pin_oe,
	input wire [7:0] port_h_reduced_drive,
	input wire [7:0] port_h_pull_en,
	input wire [7:0] port_h_periph_in,
	input wire first_serial_periph_if_en,
	input wire [3:0] first_serial_periph_if_oe,
	input wire second_serial_periph_if_en,
	input wire [3:0] second_serial_periph_if_oe,
	input wire [7:0] port_j_pin_out,
	input wire [7:0] port_j_pin_oe,
	input wire [7:0] port_j_pull_en,
	input wire [7:0] port_j_pull_up,
	input wire shared_can_controller_en,
	input wire can_transmit_pin,
	input wire i2c_en,
	input wire i2c_scl_drive_low
);
// --
// checks
// --
default clocking cb @(posedge aclk);
endclocking
default disable iff (!aresetn);
// regs start unknown: reset checks wait one edge into reset
reg in_rst_q = 1'h0;
always @(posedge aclk) in_rst_q <= !aresetn;
sequence s_ar_take;
	s_axi_arvalid && s_axi_arready;
endsequence
sequence s_pin_calm;
	$stable(port_h_pin_in) [*3];
endsequence
a_read_answer: assert property (s_ar_take |=> s_axi_rvalid)
	else $error("read not answered");
a_drive_out_only: assert property (
	(port_h_reduced_drive & ~port_h_pin_oe) == 8'h00)
	else $error("reduced drive on input");
a_pull_in_only: assert property (
	(port_h_pull_en & port_h_pin_oe) == 8'h00)
	else $error("pull on output");
a_spi_owns_h: assert property (first_serial_periph_if_en |->
	port_h_pin_oe[3:0] == first_serial_periph_if_oe)
	else $error("serial block not in control");
a_second_serial_periph_if_owns_h: assert property (second_serial_periph_if_en |->
	port_h_pin_oe[7:4] == second_serial_periph_if_oe)
	else $error("second serial block not in control");
a_can_owns_j: assert property (shared_can_controller_en |->
	port_j_pin_oe[7:6] == 2'h2 && port_j_pin_out[7] == can_transmit_pin)
	else $error("can pins wrong");
a_i2c_open_drain: assert property (
	i2c_en && !shared_can_controller_en |->
	port_j_pin_oe[7] == i2c_scl_drive_low &&
	(port_j_pin_out[7:6] & port_j_pin_oe[7:6]) == 2'h0)
	else $error("i2c not open drain");
a_j_unimpl_off: assert property (port_j_pin_oe[5:2] == 4'h0)
	else $error("unimplemented j pin driven");
a_j_reset_pull: assert property (disable iff (1'h0)
	!aresetn && in_rst_q |->
	port_j_pin_oe == 8'h00 && port_j_pull_en == 8'hc3 &&
	port_j_pull_up == 8'hc3)
	else $error("j pins not pulled in reset");
a_h_reset_hiz: assert property (disable iff (1'h0)
	!aresetn && in_rst_q |->
	port_h_pin_oe == 8'h00 && port_h_pull_en == 8'h00)
	else $error("h pins not floating in reset");
a_sync_follow: assert property (
	s_pin_calm |-> port_h_periph_in == port_h_pin_in)
	else $error("synced level lags");
endmodule
bind gpe_port gpe_port_properties gpe_port_properties_inst (.*);

// >>> verif/gpe_pins_model.sv
`timescale 1ns/1ps
module gpe_pins_model #(
	parameter [7:0] FLOAT = 8'h96
) (
	input wire [7:0] drv_out,
	input wire [7:0] drv_oe,
	input wire [7:0] pull_en,
	input wire [7:0] pull_up,
	input wire [7:0] ext_val,
	input wire [7:0] ext_drv,
	output wire [7:0] pin
);
// --
// pin resolution
// --
// an open unpulled pin shows a pattern, never the last level
wire [7:0] hiz = ~drv_oe & ~ext_drv;
assign pin = (drv_oe & drv_out) | (~drv_oe & ext_drv & ext_val)
	| (hiz & pull_en & pull_up) | (hiz & ~pull_en & FLOAT);
endmodule

// >>> verif/gpe_port_tb_top.sv
`timescale 1ns/1ps
`include "gpe_defines.vh"
module gpe_port_tb_top;
logic aclk = 1'h0, aresetn = 1'h0;
logic [11:0] s_axi_awaddr = 12'h0, s_axi_araddr = 12'h0;
logic [2:0] s_axi_awprot = 3'h0, s_axi_arprot = 3'h0;
logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
logic [31:0] s_axi_wdata = 32'h0, v;
logic [3:0] s_axi_wstrb = 4'hf;
wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
wire s_axi_rvalid, can_receive_pin, i2c_scl_in, i2c_sda_in, irq;
wire [1:0] s_axi_bresp, s_axi_rresp;
logic [1:0] rsp;
wire [31:0] s_axi_rdata;
wire [7:0] port_h_pin_in, port_h_pin_out, port_h_pin_oe, port_h_pull_up;
wire [7:0] port_h_reduced_drive, port_h_pull_en, port_h_periph_in;
wire [7:0] port_j_pin_in, port_j_pin_out, port_j_pin_oe;
wire [7:0] port_j_pull_en, port_j_pull_up;
logic first_serial_periph_if_en = 1'h0, second_serial_periph_if_en = 1'h0;
logic [3:0] first_serial_periph_if_out = 4'h0;
logic [3:0] first_serial_periph_if_oe = 4'h0;
logic [3:0] second_serial_periph_if_out = 4'h0;
logic [3:0] second_serial_periph_if_oe = 4'h0;
logic shared_can_controller_en = 1'h0, can_transmit_pin = 1'h0;
logic i2c_en = 1'h0, i2c_scl_drive_low = 1'h0, i2c_sda_drive_low = 1'h0;
logic [7:0] h_ext = 8'hff, j_ext = 8'hff, h_drv = 8'hff;
int err_total = 0, total_checks = 0;
gpe_port gpe_port_inst (.*);
gpe_pins_model gpe_pins_model_inst (.drv_out(port_h_pin_out),
	.drv_oe(port_h_pin_oe), .pull_en(port_h_pull_en),
	.pull_up(port_h_pull_up), .ext_val(h_ext), .ext_drv(h_drv),
	.pin(port_h_pin_in));
gpe_pins_model gpe_pins_model_j_inst (.drv_out(port_j_pin_out),
	.drv_oe(port_j_pin_oe), .pull_en(port_j_pull_en),
	.pull_up(port_j_pull_up), .ext_val(j_ext), .ext_drv(8'hff),
	.pin(port_j_pin_in));
always #2.5 aclk = ~aclk;
// --
// helpers
// --
task close_out;
	$display("mismatches %0d checks %0d", err_total, total_checks);
	if (err_total == 0 && total_checks > 0) $display("Finished cleanly");
	else $display("Finished with errors");
	$finish;
endtask
task chk(input string n, input logic [31:0] g, input logic [31:0] e);
	total_checks++;
	if (g !== e) begin
		err_total++;
		$display("CHECK FAILED %s exp %h got %h", n, e, g);
	end
endtask
task tmo(input logic ok);
	if (ok !== 1'h1) begin
		err_total++;
		$display("CHECK FAILED bus answer exp 1 got 0");
		close_out;
	end
endtask
task wt(input int n);
	repeat (n) @(posedge aclk);
endtask
task wr(input [7:0] i, input [7:0] d);
	int n;
	@(posedge aclk);
	s_axi_awaddr <= {2'h0, i, 2'h0};
	s_axi_wdata <= {24'h0, d};
	s_axi_awvalid <= 1'h1;
	s_axi_wvalid <= 1'h1;
	s_axi_bready <= 1'h1;
	n = 0;
	do begin
		@(posedge aclk);
		if (s_axi_awready) s_axi_awvalid <= 1'h0;
		if (s_axi_wready) s_axi_wvalid <= 1'h0;
		n++;
	end while (s_axi_bvalid !== 1'h1 && n < 60);
	s_axi_bready <= 1'h0;
	rsp = s_axi_bresp;
	tmo(s_axi_bvalid);
endtask
task rd(input [7:0] i);
	int n;
	@(posedge aclk);
	s_axi_araddr <= {2'h0, i, 2'h0};
	s_axi_arvalid <= 1'h1;
	s_axi_rready <= 1'h1;
	n = 0;
	do begin
		@(posedge aclk);
		if (s_axi_arready) s_axi_arvalid <= 1'h0;
		n++;
	end while (s_axi_rvalid !== 1'h1 && n < 60);
	s_axi_rready <= 1'h0;
	v = s_axi_rdata;
	rsp = s_axi_rresp;
	tmo(s_axi_rvalid);
endtask
task rc(input string n, input [7:0] i, input [31:0] e);
	rd(i);
	chk(n, v, e);
endtask
// --
// scenarios
// --
task t_regs;
	for (int i = 8'h22; i < 8'h27; i++) begin
		rc("reset", i[7:0], 32'h0);
		wr(i[7:0], 8'h5a);
		rc("rdback", i[7:0], 32'h5a);
		wr(i[7:0], 8'h00);
	end
	wr(8'h21, 8'h00);
	rc("pins", 8'h21, 32'hff);
	rc("unmapped", 8'h3f, 32'h0);
	chk("unmapped_resp", rsp, `GPE_RESP_SLVERR);
	wr(8'h3f, 8'h11);
	chk("wr_unmapped_resp", rsp, `GPE_RESP_SLVERR);
endtask
task t_pads;
	h_drv <= 8'h00;
	wr(8'h22, 8'h0f);
	wr(8'h23, 8'hff);
	wr(8'h24, 8'hff);
	wr(8'h25, 8'h30);
	chk("oe", port_h_pin_oe, 8'h0f);
	chk("drive", port_h_reduced_drive, 8'h0f);
	chk("pull", port_h_pull_en, 8'hf0);
	chk("pull_up", port_h_pull_up, 8'hcf);
	wt(2);
	rc("levels", 8'h21, 32'hc0);
	for (int i = 8'h22; i < 8'h26; i++) wr(i[7:0], 8'h00);
	h_drv <= 8'hff;
endtask
task t_edges;
	wr(8'h27, 8'hff);
	rd(8'h30);
	wr(8'h26, 8'h01);
	h_ext <= 8'hfe;
	wt(4);
	chk("irq_set", irq, 1'h1);
	wr(8'h27, 8'h00);
	rc("flag_kept", 8'h27, 32'h01);
	wr(8'h26, 8'h00);
	chk("irq_mask", irq, 1'h0);
	wr(8'h27, 8'h01);
	rc("flag_clr", 8'h27, 32'h0);
	wr(8'h25, 8'h02);
	h_ext <= 8'hfc;
	wt(4);
	rc("no_fall", 8'h27, 32'h0);
	h_ext <= 8'hfe;
	wt(4);
	rc("rise", 8'h27, 32'h02);
	rc("status", 8'h30, 32'h03);
	rc("status_clr", 8'h30, 32'h0);
	wr(8'h31, 8'h01);
	h_ext <= 8'hff;
	wt(2);
	h_ext <= 8'hfe;
	wt(4);
	chk("irq_evt", irq, 1'h1);
	rd(8'h30);
	chk("irq_rdclr", irq, 1'h0);
	wr(8'h31, 8'h00);
	wr(8'h25, 8'h00);
	h_ext <= 8'hff;
endtask
task t_portj;
	j_ext <= 8'hff;
	wr(8'h28, 8'h80);
	wr(8'h2a, 8'h82);
	chk("j_oe", port_j_pin_oe, 8'h82);
	wt(2);
	rc("j_read", 8'h28, 32'hc1);
	wr(8'h2a, 8'h00);
endtask
task t_owners;
	first_serial_periph_if_en <= 1'h1;
	first_serial_periph_if_oe <= 4'ha;
	first_serial_periph_if_out <= 4'h5;
	second_serial_periph_if_en <= 1'h1;
	second_serial_periph_if_oe <= 4'h3;
	second_serial_periph_if_out <= 4'h9;
	shared_can_controller_en <= 1'h1;
	can_transmit_pin <= 1'h1;
	i2c_en <= 1'h1;
	i2c_scl_drive_low <= 1'h1;
	i2c_sda_drive_low <= 1'h1;
	wt(4);
	chk("can_rx", can_receive_pin, 1'h1);
	chk("h_out", port_h_pin_out, 8'h95);
	chk("h_oe", port_h_pin_oe, 8'h3a);
	shared_can_controller_en <= 1'h0;
	wt(4);
	chk("sda_oe", port_j_pin_oe[6], 1'h1);
	chk("sda_in", i2c_sda_in, 1'h0);
	chk("scl_in", i2c_scl_in, 1'h0);
	aresetn <= 1'h0;
	wt(2);
	chk("h_rst_oe", port_h_pin_oe, 8'h00);
	chk("j_rst_oe", port_j_pin_oe, 8'h00);
	first_serial_periph_if_en <= 1'h0;
	second_serial_periph_if_en <= 1'h0;
	i2c_en <= 1'h0;
	wt(2);
	aresetn <= 1'h1;
	wt(2);
endtask
initial begin
	wt(20);
	aresetn <= 1'h1;
	t_regs;
	t_pads;
	t_edges;
	t_portj;
	t_owners;
	close_out;
end
endmodule
